// ==== common/usb_fn_pkg.sv ====
/*
 Constants and carriers for the embedded USB function endpoint block.
 Assumes the serial engine and the block share one clock and one reset.
*/
package usb_fn_pkg;
   localparam int DW = 8;
   localparam int FIFO_DEPTH = 8;
   localparam int PW = 4;
   localparam logic [PW-1:0] FIFO_FULL = 4'h8;
   localparam logic [PW-1:0] PTR_ONE = 4'h1;
   localparam logic [PW-1:0] PTR_ZERO = 4'h0;

   // Register word offsets (byte address = offset)
   localparam logic [7:0] OFF_INT = 8'h00;
   localparam logic [7:0] OFF_MASK = 8'h04;
   localparam logic [7:0] OFF_CTRL = 8'h08;
   localparam logic [7:0] OFF_TXSTAT = 8'h0c;
   localparam logic [7:0] OFF_RXSTAT = 8'h10;
   localparam logic [7:0] OFF_TXCNT = 8'h14;
   localparam logic [7:0] OFF_TXDATA = 8'h18;
   localparam logic [7:0] OFF_RXCNT = 8'h1c;
   localparam logic [7:0] OFF_RXDATA = 8'h20;

   // Interrupt register bits
   localparam int INT_CIN = 0;
   localparam int INT_COUT = 1;
   localparam int INT_EP1 = 2;
   localparam int INT_FUNCTION_RESET_FLAG = 3;
   localparam int INT_SUSP = 4;
   localparam int INT_W = 5;

   // Control register bits
   localparam int CTRL_IN_EN = 0;
   localparam int CTRL_OUT_EN = 1;
   localparam int CTRL_EP1_EN = 2;

   // Transmit status/control bits
   localparam int TX_ACK = 0;
   localparam int TX_FIFO_UNDERRUN_FLAG = 1;
   localparam int TX_FIFO_OVERRUN_FLAG = 2;
   localparam int TX_STATUS_STAGE_FLAG = 3;
   localparam int TX_SEND_EN = 4;
   localparam int TX_CLR = 5;

   // Receive status/control bits
   localparam int RX_ACK = 0;
   localparam int RX_SETUP = 1;
   localparam int RX_FIFO_UNDERRUN_FLAG = 2;
   localparam int RX_FIFO_OVERRUN_FLAG = 3;
   localparam int RX_ACC_EN = 4;
   localparam int RX_CLR = 5;

   // Events from the serial engine, each a one-cycle pulse
   typedef struct packed {
      logic bus_reset;
      logic suspend;
      logic resume;
      logic setup_begin;
      logic out_byte;
      logic [DW-1:0] out_data;
      logic out_end;
      logic out_is_setup;
      logic in_pop;
      logic in_end;
      logic ep1_end;
   } usb_evt_t;

   // Levels and data back to the serial engine
   typedef struct packed {
      logic attached;
      logic out_accept;
      logic in_ready;
      logic [DW-1:0] in_data;
      logic ep1_ready;
      logic clocks_stop;
   } usb_ctl_t;
endpackage : usb_fn_pkg

// ==== verification/tb.sv ====
/*
 Self-checking bench: Wishbone firmware tasks, a queue model of the buffers.
 Assumes the host model drives every USB event.
*/
`timescale 1ns/1ps
module tb;
   import usb_fn_pkg::*;
   logic sys_clk, arst_n, cyc, stb, we, ack, irq_n;
   logic [3:0] sel, lane;
   logic [7:0] adr, d;
   logic [31:0] wdat, rdat, r;
   usb_evt_t evt;
   usb_ctl_t ctl;
   int errors, checks_done;
   logic [7:0] q[$], rq[$];
   usb_fn_endpoints usb_fn_endpoints_inst (.sys_clk(sys_clk), .arst_n(arst_n),
      .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat),
      .dat_o(rdat), .ack_o(ack), .evt(evt), .ctl(ctl), .irq_n(irq_n));
   usb_host_model usb_host_model_inst (.sys_clk(sys_clk), .ctl(ctl), .evt(evt));
   initial sys_clk = 1'b0;
   always #5 sys_clk = ~sys_clk;
   task automatic summarize();
      $display("errors=%0d checks_done=%0d", errors, checks_done);
      if (errors == 0 && checks_done > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : summarize
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %0t %s got %0h exp %0h", $time, m, got, exp);
      end
   endtask : chk
   task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] v,
      output logic [31:0] o);
      int n;
      n = 0;
      @(posedge sys_clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= {24'h0, v};
      sel <= lane;
      do begin
         @(posedge sys_clk);
         n++;
      end while (ack !== 1'b1 && n < 40);
      if (n >= 40) begin
         errors++;
         summarize();
      end
      o = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask : wb
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      logic [31:0] o;
      wb(1'b1, a, v, o);
   endtask : wr
   // Optional mask for fields whose other bits the rules leave open
   task automatic rd(input logic [7:0] a, input logic [7:0] e, input string m,
      input logic [31:0] k = 32'hffffffff);
      logic [31:0] o;
      wb(1'b0, a, 8'h00, o);
      chk(o & k, {24'h0, e}, m);
   endtask : rd
   initial begin
      arst_n = 1'b0;
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      sel = 4'h0;
      lane = 4'h1;
      adr = '0;
      wdat = '0;
      errors = 0;
      checks_done = 0;
      d = 8'($urandom(73));
      repeat (20) @(posedge sys_clk);
      chk(32'(irq_n), 1, "irq in reset");
      arst_n <= 1'b1;
      rd(OFF_INT, 8'h00, "int reset");
      wr(OFF_CTRL, 8'h01);
      chk(32'(ctl.attached), 0, "half enabled");
      wr(OFF_CTRL, 8'h03);
      chk(32'(ctl.attached), 1, "attached");
      for (int i = 0; i < 8; i++) q.push_back(8'($urandom));
      rq = q;
      usb_host_model_inst.out_pkt(q, 1'b1);
      chk(32'(irq_n), 1, "masked");
      rd(OFF_RXSTAT, 8'h03, "setup ack");
      rd(OFF_INT, 8'h02, "int out");
      wr(OFF_MASK, 8'h1f);
      chk(32'(irq_n), 0, "irq low");
      rd(OFF_RXDATA, 8'h00, "blocked");
      rd(OFF_RXCNT, 8'h08, "no pop");
      wr(OFF_RXSTAT, 8'h03);
      chk(32'(irq_n), 1, "irq high");
      repeat (8) begin
         rd(OFF_RXCNT, 8'(rq.size()), "rx count");
         rd(OFF_RXDATA, rq.pop_front(), "rx byte");
      end
      wb(1'b0, OFF_RXDATA, 8'h00, r);
      rd(OFF_RXSTAT, 8'h04, "underrun");
      chk(32'(irq_n), 0, "fifo_underrun_flag irq");
      wr(OFF_RXSTAT, 8'h20);
      rd(OFF_RXSTAT, 8'h00, "rx clear");
      q = {8'h11, 8'h22, 8'h33};
      usb_host_model_inst.out_pkt(q, 1'b0);
      rd(OFF_RXSTAT, 8'h00, "refused");
      wr(OFF_RXSTAT, 8'h10);
      chk(32'(ctl.out_accept), 1, "accept");
      usb_host_model_inst.out_pkt(q, 1'b0);
      rd(OFF_RXSTAT, 8'h01, "out ack");
      rd(OFF_RXCNT, 8'h03, "out count");
      wr(OFF_RXSTAT, 8'h11);
      q.delete();
      for (int i = 0; i < 9; i++) q.push_back(8'($urandom));
      usb_host_model_inst.out_pkt(q, 1'b0);
      rd(OFF_RXSTAT, 8'h08, "rx overrun", 32'h08);
      rd(OFF_INT, 8'h02, "fifo_overrun_flag int");
      wr(OFF_RXSTAT, 8'h21);
      rd(OFF_INT, 8'h00, "out int clear");
      wr(OFF_TXCNT, 8'h00);
      rd(OFF_TXSTAT, 8'h10, "zero count");
      chk(32'(ctl.in_ready), 1, "in ready");
      usb_host_model_inst.pulse(4);
      rd(OFF_TXSTAT, 8'h09, "status stage");
      wr(OFF_TXSTAT, 8'h19);
      for (int i = 0; i < 9; i++) wr(OFF_TXDATA, 8'(i));
      rd(OFF_TXSTAT, 8'h14, "tx overrun");
      rd(OFF_INT, 8'h01, "tx int");
      wr(OFF_TXSTAT, 8'h20);
      rd(OFF_TXSTAT, 8'h00, "tx clear");
      q.delete();
      for (int i = 0; i < 8; i++) q.push_back(8'($urandom));
      foreach (q[i]) wr(OFF_TXDATA, q[i]);
      wr(OFF_TXCNT, 8'h08);
      wr(OFF_TXSTAT, 8'h10);
      foreach (q[i]) begin
         usb_host_model_inst.in_get(d);
         chk(32'(d), 32'(q[i]), "in byte");
      end
      usb_host_model_inst.pulse(4);
      rd(OFF_TXSTAT, 8'h01, "tx ack", 32'h07);
      rd(OFF_INT, 8'h01, "in int");
      wr(OFF_TXSTAT, 8'h01);
      rd(OFF_INT, 8'h00, "in int clear");
      usb_host_model_inst.pulse(5);
      rd(OFF_INT, 8'h00, "ep1 off");
      wr(OFF_CTRL, 8'h07);
      chk(32'(ctl.ep1_ready), 1, "ep1 ready");
      usb_host_model_inst.pulse(5);
      rd(OFF_INT, 8'h04, "ep1 on");
      usb_host_model_inst.out_pkt(q, 1'b1);
      rd(OFF_INT, 8'h02, "setup wipe");
      usb_host_model_inst.pulse(3);
      rd(OFF_RXSTAT, 8'h00, "setup drops ack");
      usb_host_model_inst.pulse(0);
      rd(OFF_INT, 8'h08, "bus reset");
      chk(32'(irq_n), 0, "reset irq");
      chk(32'(ctl.ep1_ready), 0, "ep1 dropped");
      rd(OFF_CTRL, 8'h03, "keep enables");
      rd(OFF_MASK, 8'h1f, "keep mask");
      lane = 4'h0;
      wr(OFF_MASK, 8'h00);
      lane = 4'h1;
      rd(OFF_MASK, 8'h1f, "lane off");
      rd(OFF_RXSTAT, 8'h00, "rx wiped");
      wr(OFF_INT, 8'h08);
      rd(OFF_INT, 8'h00, "reset clear");
      chk(32'(irq_n), 1, "irq release");
      usb_host_model_inst.pulse(1);
      rd(OFF_INT, 8'h10, "suspend");
      wr(OFF_INT, 8'h10);
      @(posedge sys_clk);
      chk(32'(ctl.clocks_stop), 1, "clocks stop");
      usb_host_model_inst.pulse(2);
      chk(32'(ctl.clocks_stop), 0, "resumed");
      rd(8'h40, 8'h00, "unmapped");
      summarize();
   end
   // Hang guard
   initial begin
      repeat (20000) @(posedge sys_clk);
      errors++;
      summarize();
   end
endmodule : tb

// ==== verification/usb_host_model.sv ====
/*
 Far-side model of the serial engine and the host behind it.
 Assumes sys_clk is shared with the block; every drive follows a rising edge.
*/
`timescale 1ns/1ps
module usb_host_model
   import usb_fn_pkg::*;
(
   // Clock
   input wire logic sys_clk,
   // Block side
   input wire usb_ctl_t ctl,
   output usb_evt_t evt
);
   logic [DW-1:0] last;
   initial begin
      evt = '0;
      last = '0;
   end
   // Idle data shows the inverse of the last byte so a stale value never passes
   function automatic usb_evt_t quiet();
      usb_evt_t e;
      e = '0;
      e.out_data = ~last;
      return e;
   endfunction : quiet
   task automatic idle();
      evt <= quiet();
   endtask : idle
   // 0 reset, 1 suspend, 2 resume, 3 setup, 4 in end, 5 ep1 end
   task automatic pulse(input int k);
      @(posedge sys_clk);
      case (k)
         0: evt.bus_reset <= 1'b1;
         1: evt.suspend <= 1'b1;
         2: evt.resume <= 1'b1;
         3: evt.setup_begin <= 1'b1;
         4: evt.in_end <= 1'b1;
         default: evt.ep1_end <= 1'b1;
      endcase
      @(posedge sys_clk);
      idle();
      @(posedge sys_clk);
   endtask : pulse
   task automatic out_pkt(input logic [7:0] b[$], input logic setup);
      usb_evt_t e;
      if (setup) pulse(3);
      foreach (b[i]) begin
         @(posedge sys_clk);
         evt.out_byte <= 1'b1;
         evt.out_data <= b[i];
         last = b[i];
      end
      @(posedge sys_clk);
      e = quiet();
      e.out_end = 1'b1;
      e.out_is_setup = setup;
      evt <= e;
      @(posedge sys_clk);
      idle();
      @(posedge sys_clk);
   endtask : out_pkt
   // Byte shows one cycle after the pop is taken
   task automatic in_get(output logic [7:0] d);
      @(posedge sys_clk);
      evt.in_pop <= 1'b1;
      @(posedge sys_clk);
      idle();
      @(posedge sys_clk);
      d = ctl.in_data;
   endtask : in_get
endmodule : usb_host_model

// ==== verilog/usb_fn_endpoints.sv ====
/*
 Embedded USB function endpoint logic: endpoint 0 transmit and receive
 buffers, status flags, byte counts, endpoint 1 enable, interrupt register
 with mask and active-low request, all reached over a classic Wishbone slave.
 Assumes the serial engine runs on sys_clk and presents events as pulses.
*/
// Summary of operation
// R1 - Reset clears every interrupt bit, so the request pin idles high.
// R2 - Function attaches only when both endpoint 0 enables are set.
// R3 - An interrupt bit drives the request only when its mask bit is one.
// R4 - Five interrupt bits: control in, control out, endpoint 1, reset, suspend.
// R5 - Pending unmasked interrupt drives the request pin low.
// R6 - Host reset or new setup clears all interrupts, then sets the new one.
// R7 - Endpoint 1 works only when its enable bit is set.
// R8 - Firmware times out and re-enables receive acceptance.
// R9 - Setting receive accept enable lets the next out packet be acknowledged.
// R10 - Successful in transaction sets transmit ack and raises control in.
// R11 - Firmware loads transmit bytes, writes count, restarts its timer.
// R12 - Transmit under/over-run sets its flag; transmit clear removes it.
// R13 - Receive sets ack, plus setup flag for setup; clearing both clears it.
// R14 - Receive buffer reads are blocked while the setup flag is set.
// R15 - Receive byte count reports how many bytes the buffer holds.
// R16 - Reading past receive contents sets under-run; receive clear removes it.
// R17 - Writing zero transmit count sets transmit send enable.
// R18 - Transmit buffer holds at most eight bytes per in stage.
// R19 - Receive over-run sets its flag and raises control out interrupt.
// R20 - A new setup stage clears the receive ack flag.
// R21 - Function reset clears registers except masks, endpoint 0 enables, reset bit.
// R22 - Writing 08h to the interrupt register clears the reset bit.
// R23 - Suspend sets its bit; clearing it by 10h stops the clocks.
// R24 - Request pin returns high when no set unmasked bit remains.
// R25 - No out acknowledge while accept enable is clear; cleared after a packet.
`timescale 1ns/1ps
module usb_fn_endpoints
   import usb_fn_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic arst_n,
   // Wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // Serial engine
   input wire usb_evt_t evt,
   output usb_ctl_t ctl,
   // Interrupt request pin
   output logic irq_n
);
   logic ack_reg;
   logic [31:0] rdata_reg;
   logic [2:0] ctrl_reg;
   logic [INT_W-1:0] mask_reg;
   logic ep1_flag_reg, function_reset_flag_flag_reg, susp_flag_reg, stop_reg;
   logic [5:0] tx_stat_reg, rx_stat_reg;
   logic [PW-1:0] tx_len_reg, tx_fill_reg, tx_rd_reg;
   logic [PW-1:0] rx_fill_reg, rx_rd_reg;
   logic setup_busy_reg;
   logic [DW-1:0] tx_mem [FIFO_DEPTH];
   logic [DW-1:0] rx_mem [FIFO_DEPTH];
   logic [DW-1:0] in_data_reg;
   logic [INT_W-1:0] int_vec;
   logic req, wr, rd, attached, wr_lane0;
   logic [DW-1:0] wbyte;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a == off);
   endfunction : hit

   // Request taken in the cycle before ack; ack lasts one cycle
   assign req = cyc_i && stb_i && !ack_reg;
   assign wr = req && we_i;
   assign rd = req && !we_i;
   assign wr_lane0 = wr && sel_i[0];
   assign wbyte = dat_i[DW-1:0];
   assign attached = ctrl_reg[CTRL_IN_EN] && ctrl_reg[CTRL_OUT_EN]; // [R2]

   // Control in/out bits follow their status flags, so clearing them clears it
   always_comb begin
      int_vec = '0;
      int_vec[INT_CIN] = tx_stat_reg[TX_ACK] | tx_stat_reg[TX_FIFO_UNDERRUN_FLAG]
                       | tx_stat_reg[TX_FIFO_OVERRUN_FLAG]; // [R10] [R12]
      int_vec[INT_COUT] = rx_stat_reg[RX_ACK] | rx_stat_reg[RX_SETUP]
                        | rx_stat_reg[RX_FIFO_UNDERRUN_FLAG] | rx_stat_reg[RX_FIFO_OVERRUN_FLAG]; // [R13] [R19]
      int_vec[INT_EP1] = ep1_flag_reg; // [R4]
      int_vec[INT_FUNCTION_RESET_FLAG] = function_reset_flag_flag_reg;
      int_vec[INT_SUSP] = susp_flag_reg;
   end

   assign irq_n = !(|(int_vec & mask_reg)); // [R3] [R5] [R24]

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= req;
      end
   end
   assign ack_o = ack_reg;

   // Mask survives a function reset
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         mask_reg <= '0;
      end else if (wr_lane0 && hit(adr_i, OFF_MASK)) begin
         mask_reg <= wbyte[INT_W-1:0];
      end
   end

   // Endpoint 0 enables survive a function reset; endpoint 1 enable does not
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         ctrl_reg <= '0;
      end else if (evt.bus_reset) begin
         ctrl_reg[CTRL_EP1_EN] <= 1'b0; // [R21]
      end else if (wr_lane0 && hit(adr_i, OFF_CTRL)) begin
         ctrl_reg <= wbyte[2:0];
      end
   end

   // Endpoint 1, reset and suspend flags: write one to clear, set wins
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         ep1_flag_reg <= 1'b0; // [R1]
         function_reset_flag_flag_reg <= 1'b0;
         susp_flag_reg <= 1'b0;
      end else if (evt.bus_reset) begin
         ep1_flag_reg <= 1'b0; // [R6]
         function_reset_flag_flag_reg <= 1'b1; // [R21]
         susp_flag_reg <= 1'b0;
      end else if (evt.setup_begin) begin
         ep1_flag_reg <= 1'b0; // [R6]
         function_reset_flag_flag_reg <= 1'b0;
         susp_flag_reg <= 1'b0;
      end else begin
         if (wr_lane0 && hit(adr_i, OFF_INT)) begin
            if (wbyte[INT_EP1]) ep1_flag_reg <= 1'b0;
            if (wbyte[INT_FUNCTION_RESET_FLAG]) function_reset_flag_flag_reg <= 1'b0; // [R22]
            if (wbyte[INT_SUSP]) susp_flag_reg <= 1'b0;
         end
         if (evt.ep1_end && ctrl_reg[CTRL_EP1_EN]) ep1_flag_reg <= 1'b1; // [R7]
         if (evt.suspend) susp_flag_reg <= 1'b1; // [R23]
      end
   end

   // Clocks stop once software acknowledges suspend; bus activity resumes
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         stop_reg <= 1'b0;
      end else if (evt.resume || evt.bus_reset) begin
         stop_reg <= 1'b0;
      end else if (wr_lane0 && hit(adr_i, OFF_INT) && wbyte[INT_SUSP]
                   && susp_flag_reg && !evt.suspend) begin
         stop_reg <= 1'b1; // [R23]
      end
   end

   // Transmit side: byte count, fill from software, drain by host
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         tx_stat_reg <= '0;
         tx_len_reg <= '0;
         tx_fill_reg <= '0;
         tx_rd_reg <= '0;
         in_data_reg <= '0;
      end else if (evt.bus_reset || evt.setup_begin) begin
         tx_stat_reg <= '0; // [R6] [R21]
         tx_len_reg <= '0;
         tx_fill_reg <= '0;
         tx_rd_reg <= '0;
      end else begin
         if (wr_lane0 && hit(adr_i, OFF_TXSTAT)) begin
            tx_stat_reg[TX_ACK] <= tx_stat_reg[TX_ACK] & ~wbyte[TX_ACK];
            tx_stat_reg[TX_STATUS_STAGE_FLAG] <= tx_stat_reg[TX_STATUS_STAGE_FLAG] & ~wbyte[TX_STATUS_STAGE_FLAG];
            tx_stat_reg[TX_SEND_EN] <= wbyte[TX_SEND_EN];
            if (wbyte[TX_CLR]) begin
               tx_stat_reg[TX_FIFO_UNDERRUN_FLAG] <= 1'b0; // [R12]
               tx_stat_reg[TX_FIFO_OVERRUN_FLAG] <= 1'b0;
               tx_fill_reg <= PTR_ZERO;
               tx_rd_reg <= PTR_ZERO;
            end
         end
         if (wr_lane0 && hit(adr_i, OFF_TXCNT)) begin
            tx_len_reg <= wbyte[PW-1:0];
            tx_rd_reg <= PTR_ZERO;
            if (wbyte == '0) tx_stat_reg[TX_SEND_EN] <= 1'b1; // [R17]
         end
         if (wr_lane0 && hit(adr_i, OFF_TXDATA)) begin
            if (tx_fill_reg == FIFO_FULL) begin
               tx_stat_reg[TX_FIFO_OVERRUN_FLAG] <= 1'b1; // [R12] [R18]
            end else begin
               tx_mem[tx_fill_reg[PW-2:0]] <= wbyte;
               tx_fill_reg <= tx_fill_reg + PTR_ONE;
            end
         end
         if (evt.in_pop && attached) begin
            if (tx_rd_reg >= tx_len_reg || tx_rd_reg >= tx_fill_reg) begin
               tx_stat_reg[TX_FIFO_UNDERRUN_FLAG] <= 1'b1; // [R12]
            end else begin
               in_data_reg <= tx_mem[tx_rd_reg[PW-2:0]];
               tx_rd_reg <= tx_rd_reg + PTR_ONE;
            end
         end
         if (evt.in_end && attached && tx_stat_reg[TX_SEND_EN]) begin
            tx_stat_reg[TX_ACK] <= 1'b1; // [R10]
            tx_stat_reg[TX_SEND_EN] <= 1'b0;
            if (tx_len_reg == '0) tx_stat_reg[TX_STATUS_STAGE_FLAG] <= 1'b1;
            tx_fill_reg <= PTR_ZERO;
            tx_rd_reg <= PTR_ZERO;
         end
      end
   end

   // Receive side: setup packets land whenever attached, others need accept enable
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         rx_stat_reg <= '0;
         rx_fill_reg <= '0;
         rx_rd_reg <= '0;
         setup_busy_reg <= 1'b0;
      end else if (evt.bus_reset) begin
         rx_stat_reg <= '0; // [R21]
         rx_fill_reg <= '0;
         rx_rd_reg <= '0;
         setup_busy_reg <= 1'b0;
      end else if (evt.setup_begin) begin
         rx_stat_reg <= '0; // [R6] [R20]
         rx_fill_reg <= '0;
         rx_rd_reg <= '0;
         setup_busy_reg <= attached;
      end else begin
         if (wr_lane0 && hit(adr_i, OFF_RXSTAT)) begin
            rx_stat_reg[RX_ACK] <= rx_stat_reg[RX_ACK] & ~wbyte[RX_ACK];
            rx_stat_reg[RX_SETUP] <= rx_stat_reg[RX_SETUP] & ~wbyte[RX_SETUP];
            if (wbyte[RX_ACC_EN] && !rx_stat_reg[RX_ACC_EN]) begin
               rx_stat_reg[RX_ACC_EN] <= 1'b1; // [R9]
               rx_fill_reg <= PTR_ZERO;
               rx_rd_reg <= PTR_ZERO;
            end else if (!wbyte[RX_ACC_EN]) begin
               rx_stat_reg[RX_ACC_EN] <= 1'b0;
            end
            if (wbyte[RX_CLR]) begin
               rx_stat_reg[RX_FIFO_UNDERRUN_FLAG] <= 1'b0; // [R16] [R19]
               rx_stat_reg[RX_FIFO_OVERRUN_FLAG] <= 1'b0;
            end
         end
         if (rd && hit(adr_i, OFF_RXDATA) && !rx_stat_reg[RX_SETUP]) begin // [R14]
            if (rx_rd_reg >= rx_fill_reg) begin
               rx_stat_reg[RX_FIFO_UNDERRUN_FLAG] <= 1'b1; // [R16]
            end else begin
               rx_rd_reg <= rx_rd_reg + PTR_ONE;
            end
         end
         if (evt.out_byte && ctl.out_accept) begin
            if (rx_fill_reg == FIFO_FULL) begin
               rx_stat_reg[RX_FIFO_OVERRUN_FLAG] <= 1'b1; // [R19]
            end else begin
               rx_mem[rx_fill_reg[PW-2:0]] <= evt.out_data;
               rx_fill_reg <= rx_fill_reg + PTR_ONE;
            end
         end
         if (evt.out_end && ctl.out_accept) begin
            rx_stat_reg[RX_ACK] <= 1'b1; // [R13]
            if (evt.out_is_setup) rx_stat_reg[RX_SETUP] <= 1'b1;
            rx_stat_reg[RX_ACC_EN] <= 1'b0; // [R25]
            setup_busy_reg <= 1'b0;
         end
      end
   end

   // Read data, sampled with the request
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         rdata_reg <= '0;
      end else if (rd) begin
         rdata_reg <= '0;
         case (adr_i)
            OFF_INT: rdata_reg[INT_W-1:0] <= int_vec; // [R5]
            OFF_MASK: rdata_reg[INT_W-1:0] <= mask_reg;
            OFF_CTRL: rdata_reg[2:0] <= ctrl_reg;
            OFF_TXSTAT: rdata_reg[5:0] <= tx_stat_reg;
            OFF_RXSTAT: rdata_reg[5:0] <= rx_stat_reg;
            OFF_TXCNT: rdata_reg[PW-1:0] <= tx_len_reg;
            OFF_RXCNT: rdata_reg[PW-1:0] <= rx_fill_reg - rx_rd_reg; // [R15]
            OFF_RXDATA: begin
               if (!rx_stat_reg[RX_SETUP] && rx_rd_reg < rx_fill_reg) begin
                  rdata_reg[DW-1:0] <= rx_mem[rx_rd_reg[PW-2:0]];
               end
            end
            default: rdata_reg <= '0;
         endcase
      end
   end
   assign dat_o = rdata_reg;

   // Acceptance gated by attach; setup cannot be refused
   always_comb begin
      ctl.attached = attached;
      ctl.out_accept = attached && (rx_stat_reg[RX_ACC_EN] || setup_busy_reg); // [R25]
      ctl.in_ready = attached && tx_stat_reg[TX_SEND_EN];
      ctl.in_data = in_data_reg;
      ctl.ep1_ready = attached && ctrl_reg[CTRL_EP1_EN]; // [R7]
      ctl.clocks_stop = stop_reg;
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!arst_n);

   chk_irq_follows_mask: assert property ((|(int_vec & mask_reg)) == !irq_n) // [R3]
      else $error("interrupt pin disagrees with masked flags");
   chk_reset_clears_int: assert property (evt.bus_reset |=>
      (int_vec[INT_CIN] == 1'b0 && int_vec[INT_COUT] == 1'b0 && function_reset_flag_flag_reg)) // [R6]
      else $error("function reset did not clear interrupt bits");
   chk_attach_both_en: assert property ($rose(ctl.attached) |->
      (ctrl_reg[CTRL_IN_EN] && ctrl_reg[CTRL_OUT_EN])) // [R2]
      else $error("attached without both endpoint 0 enables");
   chk_out_nak_hold: assert property ((evt.out_byte && !ctl.out_accept
      && !evt.setup_begin && !evt.bus_reset) |=> $stable(rx_fill_reg)) // [R25]
      else $error("out byte stored while not accepting");
   chk_accept_drops: assert property ((evt.out_end && ctl.out_accept
      && !evt.bus_reset && !evt.setup_begin) |=> (rx_stat_reg[RX_ACK]
      && !rx_stat_reg[RX_ACC_EN])) // [R13]
      else $error("accepted packet did not set ack and drop enable");
   chk_tx_depth: assert property (tx_fill_reg <= FIFO_FULL) // [R18]
      else $error("transmit buffer above eight bytes");
   chk_zero_count_arms: assert property ((wr_lane0 && hit(adr_i, OFF_TXCNT)
      && wbyte == '0 && !evt.bus_reset && !evt.setup_begin && !evt.in_end)
      |=> tx_stat_reg[TX_SEND_EN]) // [R17]
      else $error("zero count did not set send enable");
   chk_setup_blocks_rd: assert property ((rd && hit(adr_i, OFF_RXDATA)
      && rx_stat_reg[RX_SETUP] && !evt.bus_reset && !evt.setup_begin)
      |=> $stable(rx_rd_reg)) // [R14]
      else $error("receive read advanced while setup flag set");
   chk_ep1_gated: assert property ((evt.ep1_end && !ctrl_reg[CTRL_EP1_EN]
      && !ep1_flag_reg) |=> !ep1_flag_reg) // [R7]
      else $error("endpoint 1 flag set while disabled");

   // Events that outrank each check are left out of its trigger
   chk_tx_ack_set: assert property ((evt.in_end && attached && tx_stat_reg[TX_SEND_EN]
      && !evt.bus_reset && !evt.setup_begin) |=> (tx_stat_reg[TX_ACK] && int_vec[INT_CIN])) // [R10]
      else $error("in transaction did not set transmit ack");
   chk_tx_clear_flags: assert property ((wr_lane0 && hit(adr_i, OFF_TXSTAT) && wbyte[TX_CLR]
      && !evt.in_pop) |=> (!tx_stat_reg[TX_FIFO_UNDERRUN_FLAG] && !tx_stat_reg[TX_FIFO_OVERRUN_FLAG])) // [R12]
      else $error("transmit clear left a run flag set");
   chk_rx_underrun_set: assert property ((rd && hit(adr_i, OFF_RXDATA)
      && !rx_stat_reg[RX_SETUP] && rx_rd_reg >= rx_fill_reg && !evt.bus_reset
      && !evt.setup_begin) |=> rx_stat_reg[RX_FIFO_UNDERRUN_FLAG]) // [R16]
      else $error("empty receive read did not set under-run");
   chk_rx_overrun_set: assert property ((evt.out_byte && ctl.out_accept
      && rx_fill_reg == FIFO_FULL && !evt.bus_reset && !evt.setup_begin)
      |=> (rx_stat_reg[RX_FIFO_OVERRUN_FLAG] && int_vec[INT_COUT])) // [R19]
      else $error("receive over-run not flagged");
   chk_setup_clears_ack: assert property ((evt.setup_begin && !evt.bus_reset)
      |=> !rx_stat_reg[RX_ACK]) // [R20]
      else $error("new setup left receive ack set");
   chk_setup_wipes_int: assert property ((evt.setup_begin && !evt.bus_reset)
      |=> int_vec == '0) // [R6]
      else $error("new setup left interrupt bits set");
   chk_function_reset_flag_clear: assert property ((wr_lane0 && hit(adr_i, OFF_INT) && wbyte[INT_FUNCTION_RESET_FLAG]
      && !evt.bus_reset) |=> !function_reset_flag_flag_reg) // [R22]
      else $error("function reset bit not cleared by write");
   chk_suspend_sets: assert property ((evt.suspend && !evt.bus_reset && !evt.setup_begin)
      |=> susp_flag_reg) // [R23]
      else $error("suspend event did not set its bit");
   chk_suspend_stops: assert property ((wr_lane0 && hit(adr_i, OFF_INT) && wbyte[INT_SUSP]
      && susp_flag_reg && !evt.suspend && !evt.resume && !evt.bus_reset)
      |=> ctl.clocks_stop) // [R23]
      else $error("suspend clear did not stop clocks");
   chk_reset_keeps_mask: assert property ((evt.bus_reset && !wr) |=> ($stable(mask_reg)
      && $stable(ctrl_reg[CTRL_IN_EN]) && $stable(ctrl_reg[CTRL_OUT_EN])
      && !ctrl_reg[CTRL_EP1_EN])) // [R21]
      else $error("function reset disturbed kept registers");
endmodule : usb_fn_endpoints
